// >>> verilog/bcc_defines.svh
// Purpose: constants for the branch, call, clear and watchdog-restart execution block
// Assumes: included by bare name from the package and the design modules
// Notes:   offsets are AXI4-Lite byte addresses, one 32-bit word per register
`ifndef BCC_DEFINES_SVH
`define BCC_DEFINES_SVH

// ****************************************************************
// opcode patterns
// ****************************************************************
`define BCC_OPC_OVF_BRANCH   8'hE4
`define BCC_OPC_ZERO_BRANCH  8'hE0
`define BCC_OPC_SUB_CALL     7'h76
`define BCC_OPC_ZERO_FILE    7'h35
`define BCC_OPC_WDT_RESTART  16'h0004
`define BCC_CALL_SHADOW_BIT  8
`define BCC_BANK_BIT         8
`define BCC_ILO_LIMIT        8'h5F
`define BCC_ACC_HIGH_BANK    4'hF
`define BCC_ACC_LOW_BANK     4'h0
`define BCC_ZERO_BYTE        8'h00

// ****************************************************************
// program counter
// ****************************************************************
`define BCC_PC_W             21
`define BCC_PC_STEP          21'h000002
`define BCC_PC_RST           21'h000000

// ****************************************************************
// instruction phases, one-hot
// ****************************************************************
`define BCC_Q1               0
`define BCC_Q2               1
`define BCC_Q3               2
`define BCC_Q4               3
`define BCC_Q_RST            4'h1

// ****************************************************************
// register map
// ****************************************************************
`define BCC_AXI_AW           8
`define BCC_REG_CTRL         8'h00
`define BCC_REG_WORK         8'h04
`define BCC_REG_FLAGS        8'h08
`define BCC_REG_BANK         8'h0C
`define BCC_REG_INDEX        8'h10
`define BCC_REG_SHADOW       8'h14
`define BCC_REG_PC           8'h18
`define BCC_CTRL_RUN         0
`define BCC_CTRL_EXT         1
`define BCC_FLG_ZERO         0
`define BCC_FLG_OVF          1
`define BCC_FLG_PD_N         2
`define BCC_FLG_TO_N         3
`define BCC_FLAGS_RST        4'hC
`define BCC_RESP_OKAY        2'h0
`define BCC_RESP_SLVERR      2'h2

`endif

// >>> verilog/bcc_pkg.sv
// Purpose: types shared by the execution block and its phase sequencer
// Assumes: bcc_defines.svh on the include path
// Notes:   states are one-hot
`include "bcc_defines.svh"
package bcc_pkg;

    typedef enum logic [1:0] {
        st_exec = 2'h1,
        st_idle = 2'h2
    } state_type;

    typedef struct packed {
        logic [3:0] q;
    } seq_state_type;

    typedef struct packed {
        state_type              state;
        logic [15:0]            ir;
        logic [`BCC_PC_W-1:0]   pc;
        logic                   run;
        logic                   ext;
        logic [7:0]             work;
        logic [3:0]             flags;
        logic [3:0]             bank_select_reg;
        logic [11:0]            idx;
        logic [7:0]             work_shadow;
        logic [3:0]             flags_shadow;
        logic [3:0]             bank_select_shadow;
        logic                   dm_we;
        logic [11:0]            dm_addr;
        logic [7:0]             dm_wdata;
        logic                   stack_push;
        logic [`BCC_PC_W-1:0]   stack_data;
        logic                   wdt_clear;
        logic                   discard;
        logic                   awrdy;
        logic                   wrdy;
        logic                   aw_have;
        logic                   w_have;
        logic [`BCC_AXI_AW-1:0] awaddr;
        logic [31:0]            wdata;
        logic [3:0]             wstrb;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   arrdy;
        logic                   rvalid;
        logic [31:0]            rdata;
        logic [1:0]             rresp;
    } core_state_type;

endpackage : bcc_pkg

// >>> verilog/phase_if.sv
// Purpose: carries the run level and the four instruction phases
// Assumes: one clock domain
// Notes:   q is one-hot, bit 0 is the first phase
`timescale 1ns/1ps
`default_nettype none
interface phase_if;
    logic       run;
    logic [3:0] q;
    modport seq  (input run, output q);
    modport core (output run, input q);
endinterface : phase_if
`default_nettype wire

// >>> verilog/q_phase_seq.sv
// Purpose: four-phase instruction cycle sequencer
// Assumes: run comes from a register on the same clock
// Notes:   holds its phase while run is low
`timescale 1ns/1ps
`default_nettype none
`include "bcc_defines.svh"
module q_phase_seq (
    input  wire logic i_sys_clk,
    input  wire logic i_rst,
    phase_if.seq      ph
);
    bcc_pkg::seq_state_type r_ff;
    bcc_pkg::seq_state_type nxt_r;

    // ****************************************************************
    // phase rotation
    // ****************************************************************
    always_comb begin
        nxt_r = r_ff;
        if (ph.run) begin
            nxt_r.q = {r_ff.q[2:0], r_ff.q[3]};
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            r_ff.q <= `BCC_Q_RST;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign ph.q = r_ff.q;

    a_phase_onehot: assert property (@(posedge i_sys_clk) disable iff (i_rst) $onehot(r_ff.q))
        else $error("phase not one-hot");

endmodule : q_phase_seq
`default_nettype wire

// >>> verilog/branch_call_clear_exec.sv
// Purpose: executes overflow/zero branches, subroutine call, byte clear and watchdog restart
// Assumes: i_instr is the program word at o_pc, from logic on the same clock
// Notes:   one instruction cycle is four clocks; control and state over AXI4-Lite
//
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "bcc_defines.svh"
// Behaviour
// - overflow branch opcode taken when overflow set
// - zero branch opcode taken when zero set
// - taken target is incremented pc plus 2n
// - branch one cycle, two when taken
// - call reaches whole program space, 20-bit literal
// - call pushes pc plus four first
// - shadow bit one saves work, flags, bank
// - shadow bit zero leaves shadows untouched
// - literal loads pc bits 20 to 1
// - byte clear writes zero, sets zero flag
// - byte clear opcode 0110101 plus a, f
// - bank bit zero selects common window
// - bank bit one uses bank select register
// - extended set, a zero, f<=95 indexed
// - watchdog restart clears counter, sets flags
module branch_call_clear_exec (
    input  wire logic                   i_sys_clk,
    input  wire logic                   i_rst,
    input  wire logic [15:0]            i_instr,
    output logic      [`BCC_PC_W-1:0]   o_pc,
    output logic                        o_discard,
    output logic                        o_dm_we,
    output logic      [11:0]            o_dm_addr,
    output logic      [7:0]             o_dm_wdata,
    output logic                        o_stack_push,
    output logic      [`BCC_PC_W-1:0]   o_stack_data,
    output logic                        o_wdt_clear,
    output logic                        o_timeout_flag_n,
    output logic                        o_powerdown_flag_n,
    input  wire logic                   i_awvalid,
    output logic                        o_awready,
    input  wire logic [`BCC_AXI_AW-1:0] i_awaddr,
    input  wire logic                   i_wvalid,
    output logic                        o_wready,
    input  wire logic [31:0]            i_wdata,
    input  wire logic [3:0]             i_wstrb,
    output logic                        o_bvalid,
    input  wire logic                   i_bready,
    output logic      [1:0]             o_bresp,
    input  wire logic                   i_arvalid,
    output logic                        o_arready,
    input  wire logic [`BCC_AXI_AW-1:0] i_araddr,
    output logic                        o_rvalid,
    input  wire logic                   i_rready,
    output logic      [31:0]            o_rdata,
    output logic      [1:0]             o_rresp
);
    bcc_pkg::core_state_type r_ff;
    bcc_pkg::core_state_type nxt_r;
    phase_if                 ph ();
    logic [3:0]              pq;
    logic                    is_ovf_br;
    logic                    is_zero_br;
    logic                    is_call;
    logic                    is_zero_file;
    logic                    is_wdt;
    logic                    br_taken;
    logic [`BCC_PC_W-1:0]    br_target;
    logic [19:0]             call_lit;

    // ****************************************************************
    // byte-lane merge and data address resolution
    // ****************************************************************
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction : lane_merge

    function automatic logic [11:0] file_addr(input logic       a,
                                              input logic [7:0] f,
                                              input logic       ext,
                                              input logic [3:0] bsel,
                                              input logic [11:0] idx);
        logic [11:0] res;
        if (a) begin
            res = {bsel, f};
        end else if (ext && (f <= `BCC_ILO_LIMIT)) begin
            res = idx + {4'h0, f};
        end else if (f > `BCC_ILO_LIMIT) begin
            res = {`BCC_ACC_HIGH_BANK, f};
        end else begin
            res = {`BCC_ACC_LOW_BANK, f};
        end
        return res;
    endfunction : file_addr

    // ****************************************************************
    // phase sequencer
    // ****************************************************************
    q_phase_seq u_seq (
        .i_sys_clk (i_sys_clk),
        .i_rst     (i_rst),
        .ph        (ph.seq)
    );
    assign ph.run = r_ff.run;
    assign pq     = ph.q;

    // ****************************************************************
    // decode
    // ****************************************************************
    assign is_ovf_br    = (r_ff.ir[15:8] == `BCC_OPC_OVF_BRANCH);
    assign is_zero_br   = (r_ff.ir[15:8] == `BCC_OPC_ZERO_BRANCH);
    assign is_call      = (r_ff.ir[15:9] == `BCC_OPC_SUB_CALL);
    assign is_zero_file = (r_ff.ir[15:9] == `BCC_OPC_ZERO_FILE);
    assign is_wdt       = (r_ff.ir == `BCC_OPC_WDT_RESTART);
    assign br_taken     = (is_ovf_br && r_ff.flags[`BCC_FLG_OVF]) ||
                          (is_zero_br && r_ff.flags[`BCC_FLG_ZERO]);
    assign br_target    = r_ff.pc + {{12{r_ff.ir[7]}}, r_ff.ir[7:0], 1'b0};
    assign call_lit     = {i_instr[11:0], r_ff.ir[7:0]};

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        logic [31:0] wv;
        wv                = 32'h0000_0000;
        nxt_r             = r_ff;
        nxt_r.dm_we       = 1'b0;
        nxt_r.stack_push  = 1'b0;
        nxt_r.wdt_clear   = 1'b0;
        // write channels
        if (i_awvalid && r_ff.awrdy) begin
            nxt_r.aw_have = 1'b1;
            nxt_r.awaddr  = i_awaddr;
        end
        if (i_wvalid && r_ff.wrdy) begin
            nxt_r.w_have = 1'b1;
            nxt_r.wdata  = i_wdata;
            nxt_r.wstrb  = i_wstrb;
        end
        if (r_ff.bvalid && i_bready) begin
            nxt_r.bvalid = 1'b0;
        end
        if (r_ff.aw_have && r_ff.w_have && !r_ff.bvalid) begin
            nxt_r.aw_have = 1'b0;
            nxt_r.w_have  = 1'b0;
            nxt_r.bvalid  = 1'b1;
            nxt_r.bresp   = `BCC_RESP_OKAY;
            case (r_ff.awaddr)
                `BCC_REG_CTRL: begin
                    wv = lane_merge({30'h0, r_ff.ext, r_ff.run}, r_ff.wdata, r_ff.wstrb);
                    nxt_r.run = wv[`BCC_CTRL_RUN];
                    nxt_r.ext = wv[`BCC_CTRL_EXT];
                end
                `BCC_REG_WORK: begin
                    wv = lane_merge({24'h0, r_ff.work}, r_ff.wdata, r_ff.wstrb);
                    nxt_r.work = wv[7:0];
                end
                `BCC_REG_FLAGS: begin
                    wv = lane_merge({28'h0, r_ff.flags}, r_ff.wdata, r_ff.wstrb);
                    nxt_r.flags = wv[3:0];
                end
                `BCC_REG_BANK: begin
                    wv = lane_merge({28'h0, r_ff.bank_select_reg}, r_ff.wdata, r_ff.wstrb);
                    nxt_r.bank_select_reg = wv[3:0];
                end
                `BCC_REG_INDEX: begin
                    wv = lane_merge({20'h0, r_ff.idx}, r_ff.wdata, r_ff.wstrb);
                    nxt_r.idx = wv[11:0];
                end
                `BCC_REG_SHADOW, `BCC_REG_PC: begin
                    nxt_r.bresp = `BCC_RESP_OKAY;
                end
                default: begin
                    nxt_r.bresp = `BCC_RESP_SLVERR;
                end
            endcase
        end
        nxt_r.awrdy = !nxt_r.aw_have && !nxt_r.bvalid;
        nxt_r.wrdy  = !nxt_r.w_have && !nxt_r.bvalid;
        // read channels
        if (r_ff.rvalid && i_rready) begin
            nxt_r.rvalid = 1'b0;
        end
        if (i_arvalid && r_ff.arrdy) begin
            nxt_r.rvalid = 1'b1;
            nxt_r.rresp  = `BCC_RESP_OKAY;
            case (i_araddr)
                `BCC_REG_CTRL:   nxt_r.rdata = {30'h0, r_ff.ext, r_ff.run};
                `BCC_REG_WORK:   nxt_r.rdata = {24'h0, r_ff.work};
                `BCC_REG_FLAGS:  nxt_r.rdata = {28'h0, r_ff.flags};
                `BCC_REG_BANK:   nxt_r.rdata = {28'h0, r_ff.bank_select_reg};
                `BCC_REG_INDEX:  nxt_r.rdata = {20'h0, r_ff.idx};
                `BCC_REG_SHADOW: nxt_r.rdata = {16'h0, r_ff.bank_select_shadow, r_ff.flags_shadow,
                                                r_ff.work_shadow};
                `BCC_REG_PC:     nxt_r.rdata = {11'h0, r_ff.pc};
                default: begin
                    nxt_r.rdata = 32'h0000_0000;
                    nxt_r.rresp = `BCC_RESP_SLVERR;
                end
            endcase
        end
        nxt_r.arrdy = !nxt_r.rvalid;
        // execution, after software writes so hardware sets win
        if (r_ff.run && pq[`BCC_Q1] && (r_ff.state == bcc_pkg::st_exec)) begin
            nxt_r.ir = i_instr;
            nxt_r.pc = r_ff.pc + `BCC_PC_STEP;
        end
        if (r_ff.run && pq[`BCC_Q3] && (r_ff.state == bcc_pkg::st_exec)) begin
            if (is_call) begin
                nxt_r.stack_push = 1'b1;
                nxt_r.stack_data = r_ff.pc + `BCC_PC_STEP;
                if (r_ff.ir[`BCC_CALL_SHADOW_BIT]) begin
                    nxt_r.work_shadow        = r_ff.work;
                    nxt_r.flags_shadow       = r_ff.flags;
                    nxt_r.bank_select_shadow = r_ff.bank_select_reg;
                end
            end
            if (is_wdt) begin
                nxt_r.wdt_clear              = 1'b1;
                nxt_r.flags[`BCC_FLG_TO_N]   = 1'b1;
                nxt_r.flags[`BCC_FLG_PD_N]   = 1'b1;
            end
        end
        if (r_ff.run && pq[`BCC_Q4]) begin
            if (r_ff.state == bcc_pkg::st_idle) begin
                nxt_r.state = bcc_pkg::st_exec;
            end else if (br_taken) begin
                nxt_r.pc    = br_target;
                nxt_r.state = bcc_pkg::st_idle;
            end else if (is_call) begin
                nxt_r.pc    = {call_lit, 1'b0};
                nxt_r.state = bcc_pkg::st_idle;
            end else if (is_zero_file) begin
                nxt_r.dm_we   = 1'b1;
                nxt_r.dm_wdata = `BCC_ZERO_BYTE;
                nxt_r.dm_addr = file_addr(r_ff.ir[`BCC_BANK_BIT], r_ff.ir[7:0], r_ff.ext,
                                          r_ff.bank_select_reg, r_ff.idx);
                nxt_r.flags[`BCC_FLG_ZERO] = 1'b1;
            end
        end
        nxt_r.discard = (nxt_r.state == bcc_pkg::st_idle);
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            r_ff       <= '0;
            r_ff.state <= bcc_pkg::st_exec;
            r_ff.pc    <= `BCC_PC_RST;
            r_ff.flags <= `BCC_FLAGS_RST;
            r_ff.awrdy <= 1'b1;
            r_ff.wrdy  <= 1'b1;
            r_ff.arrdy <= 1'b1;
        end else begin
            r_ff <= nxt_r;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign o_pc               = r_ff.pc;
    assign o_discard          = r_ff.discard;
    assign o_dm_we            = r_ff.dm_we;
    assign o_dm_addr          = r_ff.dm_addr;
    assign o_dm_wdata         = r_ff.dm_wdata;
    assign o_stack_push       = r_ff.stack_push;
    assign o_stack_data       = r_ff.stack_data;
    assign o_wdt_clear        = r_ff.wdt_clear;
    assign o_timeout_flag_n   = r_ff.flags[`BCC_FLG_TO_N];
    assign o_powerdown_flag_n = r_ff.flags[`BCC_FLG_PD_N];
    assign o_awready          = r_ff.awrdy;
    assign o_wready           = r_ff.wrdy;
    assign o_bvalid           = r_ff.bvalid;
    assign o_bresp            = r_ff.bresp;
    assign o_arready          = r_ff.arrdy;
    assign o_rvalid           = r_ff.rvalid;
    assign o_rdata            = r_ff.rdata;
    assign o_rresp            = r_ff.rresp;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    logic act_q3;
    logic act_q4;
    assign act_q3 = r_ff.run && pq[`BCC_Q3] && (r_ff.state == bcc_pkg::st_exec);
    assign act_q4 = r_ff.run && pq[`BCC_Q4] && (r_ff.state == bcc_pkg::st_exec);

    sequence s_ovf_taken;
        act_q4 && is_ovf_br && r_ff.flags[`BCC_FLG_OVF];
    endsequence
    sequence s_zero_taken;
        act_q4 && is_zero_br && r_ff.flags[`BCC_FLG_ZERO];
    endsequence
    sequence s_idle_cycle;
        o_discard && (r_ff.state == bcc_pkg::st_idle);
    endsequence

    a_ovf_branch: assert property (s_ovf_taken |=> (o_pc == $past(br_target)))
        else $error("overflow branch target wrong");
    a_zero_branch: assert property (s_zero_taken |=> (o_pc == $past(br_target)))
        else $error("zero branch target wrong");
    a_branch_offset: assert property (act_q4 && br_taken
            |=> o_pc == $past(r_ff.pc) + 21'($signed($past(r_ff.ir[7:0])) * 2))
        else $error("branch offset not doubled");
    a_not_taken: assert property (act_q4 && is_zero_br && !r_ff.flags[`BCC_FLG_ZERO]
            |=> $stable(o_pc) && !o_discard)
        else $error("untaken branch changed flow");
    a_taken_idle: assert property ((s_ovf_taken or s_zero_taken)
            |=> s_idle_cycle)
        else $error("taken branch not followed by idle cycle");
    a_call_push: assert property (act_q3 && is_call
            |=> o_stack_push && (o_stack_data == $past(r_ff.pc) + `BCC_PC_STEP))
        else $error("call return address wrong");
    a_shadow_save: assert property (act_q3 && is_call && r_ff.ir[`BCC_CALL_SHADOW_BIT]
            |=> (r_ff.work_shadow == $past(r_ff.work)) && (r_ff.flags_shadow == $past(r_ff.flags)))
        else $error("shadow not saved");
    a_shadow_keep: assert property (act_q3 && is_call && !r_ff.ir[`BCC_CALL_SHADOW_BIT]
            |=> $stable(r_ff.work_shadow) && $stable(r_ff.bank_select_shadow))
        else $error("shadow changed");
    a_call_target: assert property (act_q4 && is_call && !br_taken
            |=> (o_pc == {$past(call_lit), 1'b0}) && o_discard)
        else $error("call target wrong");
    a_clear_byte: assert property (act_q4 && is_zero_file && !br_taken && !is_call
            |=> o_dm_we && (o_dm_wdata == `BCC_ZERO_BYTE) && r_ff.flags[`BCC_FLG_ZERO])
        else $error("byte clear failed");
    a_bank_select: assert property (o_dm_we && $past(r_ff.ir[`BCC_BANK_BIT])
            |-> (o_dm_addr[11:8] == $past(r_ff.bank_select_reg)))
        else $error("bank select not used");
    a_wdt_restart: assert property (act_q3 && is_wdt
            |=> o_wdt_clear && o_timeout_flag_n && o_powerdown_flag_n)
        else $error("watchdog restart failed");

endmodule : branch_call_clear_exec
`default_nettype wire

// >>> testbench/pmem.sv
// Purpose: program store, data memory and return stack model
// Assumes: word fetched combinationally at the program counter
// Notes: logs data writes, keeps the last push, counts watchdog restarts
`timescale 1ns/1ps
`default_nettype none
module pmem (
    input  wire logic        i_sys_clk,
    input  wire logic [20:0] i_pc,
    input  wire logic        i_dm_we,
    input  wire logic [11:0] i_dm_addr,
    input  wire logic [7:0]  i_dm_wdata,
    input  wire logic        i_stack_push,
    input  wire logic [20:0] i_stack_data,
    input  wire logic        i_wdt_clear,
    output logic      [15:0] o_instr
);
    logic [15:0] rom [0:8191];
    logic [19:0] dm_log [$];
    logic [20:0] push_ff;
    int          wdt_cnt;
    assign o_instr = rom[i_pc[13:1]];
    initial begin
        wdt_cnt = 0;
        push_ff = '0;
        foreach (rom[i]) rom[i] = 16'hFFFF;
    end
    always @(posedge i_sys_clk) begin
        if (i_dm_we) dm_log.push_back({i_dm_wdata, i_dm_addr});
        if (i_stack_push) push_ff <= i_stack_data;
        if (i_wdt_clear) wdt_cnt <= wdt_cnt + 1;
    end
endmodule : pmem
`default_nettype wire

// >>> testbench/testbench.sv
// Purpose: self-checking bench for the execution block
// Assumes: pmem supplies program words
// Notes: one program runs every instruction kind
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk, rst, awv, wv, bry, arv, rry, dwe, psh, wclr, ton, pdn, awr, wr, bv, arr, rv, dsc;
    logic [7:0]  awa, ara, rnd, dwd;
    logic [31:0] wd, rd;
    logic [1:0]  rr, br;
    logic [15:0] ins;
    logic [20:0] pc, pdat, tg;
    logic [11:0] dad;
    int          miscompares, cmp_count, ndisc;
    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    branch_call_clear_exec u_branch_call_clear_exec (.i_sys_clk(clk), .i_rst(rst), .i_instr(ins), .o_pc(pc),
        .o_discard(dsc), .o_dm_we(dwe), .o_dm_addr(dad), .o_dm_wdata(dwd), .o_stack_push(psh),
        .o_stack_data(pdat), .o_wdt_clear(wclr), .o_timeout_flag_n(ton), .o_powerdown_flag_n(pdn),
        .i_awvalid(awv), .o_awready(awr), .i_awaddr(awa), .i_wvalid(wv), .o_wready(wr), .i_wdata(wd),
        .i_wstrb(4'hF), .o_bvalid(bv), .i_bready(bry), .o_bresp(br), .i_arvalid(arv), .o_arready(arr),
        .i_araddr(ara), .o_rvalid(rv), .i_rready(rry), .o_rdata(rd), .o_rresp(rr));
    pmem u_pmem (.i_sys_clk(clk), .i_pc(pc), .i_dm_we(dwe), .i_dm_addr(dad), .i_dm_wdata(dwd),
        .i_stack_push(psh), .i_stack_data(pdat), .i_wdt_clear(wclr), .o_instr(ins));
    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction : lfsr
    function automatic logic [20:0] brt(input logic [20:0] p, input logic [7:0] n);
        return p + 21'h000002 + {{12{n[7]}}, n, 1'b0};
    endfunction : brt
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task test_done;
        $display("compares %0d errors %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : test_done
    task fail;
        miscompares++;
        test_done;
    endtask : fail
    task axw(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        awv <= 1;
        wv <= 1;
        awa <= a;
        wd <= d;
        do begin
            @(posedge clk);
            if (awr) awv <= 0;
            if (wr) wv <= 0;
            n++;
        end while (bv !== 1'b1 && n < 50);
        if (n >= 50) fail;
    endtask : axw
    task axr(input logic [7:0] a);
        int n;
        n = 0;
        arv <= 1;
        ara <= a;
        do begin
            @(posedge clk);
            if (arr) arv <= 0;
            n++;
        end while (rv !== 1'b1 && n < 50);
        if (n >= 50) fail;
    endtask : axr
    always @(posedge clk) begin
        if (dsc === 1'b1) ndisc <= ndisc + 1;
    end
    initial begin
        repeat (20000) @(posedge clk);
        fail;
    end
    initial begin
        {rst, bry, rry} = 3'h7;
        {awv, wv, arv, awa, ara, wd} = '0;
        miscompares = 0;
        cmp_count = 0;
        ndisc = 0;
        rnd = lfsr(8'h29);
        repeat (6) @(posedge clk);
        rst <= 0;
        u_pmem.rom[0] = 16'hE07F;
        u_pmem.rom[1] = 16'h6B12;
        u_pmem.rom[2] = 16'hE002;
        u_pmem.rom[3] = 16'h6B55;
        u_pmem.rom[4] = 16'h6B55;
        tg = brt(21'h000004, 8'h02);
        u_pmem.rom[tg[13:1]] = 16'h0004;
        tg = brt(21'h00000C, 8'h01);
        u_pmem.rom[6] = 16'hE401;
        u_pmem.rom[7] = 16'h6B55;
        u_pmem.rom[tg[13:1]] = 16'hED34;
        u_pmem.rom[9] = 16'hF012;
        u_pmem.rom[13'h1234] = 16'h6A20;
        u_pmem.rom[13'h1235] = 16'h6AA0;
        u_pmem.rom[13'h1236] = 16'hEC00;
        u_pmem.rom[13'h1237] = 16'hF0F0;
        @(posedge clk);
        axw(8'h04, {24'h0, rnd});
        axw(8'h0C, 32'h00000003);
        axw(8'h08, 32'h00000002);
        axw(8'h10, {20'h0, 4'h1, rnd});
        axw(8'h00, 32'h00000003);
        for (int i = 0; i < 400 && u_pmem.dm_log.size() < 3; i++) @(negedge clk);
        if (u_pmem.dm_log.size() < 3) fail;
        repeat (10) @(posedge clk);
        chk("dm0", {12'h0, u_pmem.dm_log[0]}, 32'h00000312);
        chk("dm1", {12'h0, u_pmem.dm_log[1]}, {20'h0, {4'h1, rnd} + 12'h020});
        chk("dm2", {12'h0, u_pmem.dm_log[2]}, 32'h00000FA0);
        chk("push", {11'h0, u_pmem.push_ff}, 32'h00002470);
        chk("disc", ndisc, 32'h00000010);
        chk("wdt", u_pmem.wdt_cnt, 32'h00000001);
        chk("tpd", {30'h0, ton, pdn}, 32'h00000003);
        axr(8'h14);
        chk("shadow", rd, {16'h0, 8'h3F, rnd});
        axr(8'h08);
        chk("flags", rd, 32'h0000000F);
        axr(8'h1C);
        chk("resp", {30'h0, rr}, 32'h00000002);
        axw(8'h1C, 32'h00000000);
        chk("bresp", {30'h0, br}, 32'h00000002);
        test_done;
    end
endmodule : testbench
`default_nettype wire
